// ===== common/iwd_pkg.sv
// Constants, codes and carrier types of the interrupt wait dispatcher
package iwd_pkg;

   localparam int NUM_SRC = 16;
   localparam int SRC_W   = 4;
   localparam int EXT_N   = 8;
   localparam int PC_N    = 7;
   localparam int PORT_W  = 8;
   localparam int MODE_W  = 8;
   localparam int TASK_W  = 4;
   localparam int CHAN_W  = 4;
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 32;

   // Source numbering: ext 0..7, comparator, pin-change ports A..G
   localparam logic [SRC_W-1:0] SRC_CMP = 4'h8;
   localparam logic [SRC_W-1:0] SRC_PC0 = 4'h9;

   // External trigger codes
   localparam logic [MODE_W-1:0] EXT_LOW_CODE        = 8'h10;
   localparam logic [MODE_W-1:0] EXT_ANY_CHANGE_CODE = 8'h14;
   localparam logic [MODE_W-1:0] EXT_FALL_CODE       = 8'h18;
   localparam logic [MODE_W-1:0] EXT_RISE_CODE       = 8'h1c;

   // Comparator codes, low two bits of the mode
   localparam logic [1:0] CMP_ANY_EDGE_CODE = 2'h0;
   localparam logic [1:0] CMP_FALL_CODE     = 2'h2;
   localparam logic [1:0] CMP_RISE_CODE     = 2'h3;
   localparam logic [1:0] WIN_ABOVE_CODE    = 2'h0;
   localparam logic [1:0] WIN_INSIDE_CODE   = 2'h1;
   localparam logic [1:0] WIN_BELOW_CODE    = 2'h2;
   localparam logic [1:0] WIN_OUTSIDE_CODE  = 2'h3;
   localparam int CMP_BANDGAP_BIT = 6;
   localparam int CMP_WINDOW_BIT  = 7;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] REG_CTRL    = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h04;
   localparam logic [ADDR_W-1:0] REG_CLEAR   = 8'h08;
   localparam logic [ADDR_W-1:0] REG_ENABLE  = 8'h0c;
   localparam logic [ADDR_W-1:0] REG_WAITERS = 8'h10;
   localparam int CTRL_NATIVE_BIT = 0;
   localparam int CTRL_MUXNEG_BIT = 1;
   localparam int CTRL_CHAN_LSB   = 4;

   // Virtual-machine rank order, rank 0 first
   localparam logic [NUM_SRC-1:0][SRC_W-1:0] VM_ORDER = {
      4'hf, 4'he, 4'hd, 4'hc, 4'hb, 4'ha, 4'h9, 4'h7,
      4'h6, 4'h5, 4'h4, 4'h3, 4'h8, 4'h2, 4'h1, 4'h0};

   typedef struct packed {
      logic                valid;
      logic [SRC_W-1:0]    src;
      logic [MODE_W-1:0]   mode;
      logic [TASK_W-1:0]   task_id;
   } iwd_await_t;

   typedef struct packed {
      logic done;
      logic immediate;
   } iwd_answer_t;

   typedef struct packed {
      logic                valid;
      logic [SRC_W-1:0]    src;
      logic [TASK_W-1:0]   task_id;
   } iwd_wake_t;

   typedef struct packed {
      logic [EXT_N-1:0]                ext_s1;
      logic [EXT_N-1:0]                ext_s2;
      logic [EXT_N-1:0]                ext_prev;
      logic [PC_N-1:0][PORT_W-1:0]     pc_s1;
      logic [PC_N-1:0][PORT_W-1:0]     pc_s2;
      logic [PC_N-1:0][PORT_W-1:0]     pc_prev;
      logic [1:0]                      cmp_s1;
      logic [1:0]                      cmp_s2;
      logic [1:0]                      cmp_prev;
      logic [3:0]                      win_prev;
      logic [NUM_SRC-1:0]              waiting;
      logic [NUM_SRC-1:0]              pend;
      logic [NUM_SRC-1:0][MODE_W-1:0]  mode;
      logic [NUM_SRC-1:0][TASK_W-1:0]  task_id;
      logic [NUM_SRC-1:0]              status;
      logic [NUM_SRC-1:0]              enable;
      logic                            native;
      logic                            muxneg;
      logic [CHAN_W-1:0]               chan;
      logic                            ack;
      logic [DATA_W-1:0]               dat;
      iwd_answer_t                     answer;
      iwd_wake_t                       wake;
   } iwd_state_t;

endpackage

// ===== rtl/iwd_dispatcher.sv
// Interrupt wait dispatcher: trigger detection, waiters, priority wake-up
//
// Our own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module iwd_dispatcher (
   input  wire  logic                     clk_i,
   input  wire  logic                     rst_i,
   input  wire  logic                     wb_cyc_i,
   input  wire  logic                     wb_stb_i,
   input  wire  logic                     wb_we_i,
   input  wire  logic [7:0]               wb_adr_i,
   input  wire  logic [3:0]               wb_sel_i,
   input  wire  logic [31:0]              wb_dat_i,
   output logic       [31:0]              wb_dat_o,
   output logic                           wb_ack_o,
   output logic                           irq_o,
   input  wire  logic [7:0]               ext_pad_i,
   input  wire  logic [7:0]               ext_drv_i,
   input  wire  logic [7:0]               ext_drv_oe_n_i,
   input  wire  logic [55:0]              pc_port_i,
   input  wire  logic [1:0]               cmp_out_i,
   output logic                           cmp_pos_bandgap_o,
   output logic                           cmp_neg_mux_o,
   output logic                           cmp_window_o,
   output logic       [3:0]               analog_channel_select_o,
   input  wire  iwd_pkg::iwd_await_t      await_event_request_i,
   output iwd_pkg::iwd_answer_t           await_answer_o,
   input  wire  logic                     irq_global_en_i,
   input  wire  logic                     task_locked_i,
   output iwd_pkg::iwd_wake_t             wake_o
);

   iwd_pkg::iwd_state_t st_r;
   iwd_pkg::iwd_state_t st_nxt;

   logic [iwd_pkg::EXT_N-1:0]   ext_lvl;
   logic [iwd_pkg::NUM_SRC-1:0] ev;
   logic [3:0]                  win_cond;
   // One driver per event vector, merged below
   logic [iwd_pkg::EXT_N-1:0]   ev_ext;
   logic                        ev_cmp;
   logic [iwd_pkg::PC_N-1:0]    ev_pc;

   ////////////////////////////////////////////////////////////////////////
   // Decode helpers

   function automatic logic reg_hit(input logic [7:0] adr,
                                    input logic [7:0] off);
      return adr == off;
   endfunction

   function automatic logic [15:0] lane_mask(input logic [3:0] sel);
      return {{8{sel[1]}}, {8{sel[0]}}};
   endfunction

   // Same trigger decode serves every external line
   function automatic logic ext_event(input logic [7:0] mode,
                                      input logic       lvl,
                                      input logic       prev);
      logic e;
      case (mode)
         iwd_pkg::EXT_LOW_CODE:        e = ~lvl;
         iwd_pkg::EXT_ANY_CHANGE_CODE: e = lvl ^ prev;
         iwd_pkg::EXT_FALL_CODE:       e = prev & ~lvl;
         iwd_pkg::EXT_RISE_CODE:       e = ~prev & lvl;
         default:                      e = 1'b0;
      endcase
      return e;
   endfunction

   // Reserved codes are refused at request time
   function automatic logic mode_ok(input logic [3:0] src,
                                    input logic [7:0] mode);
      logic ok;
      ok = 1'b1;
      if (src < iwd_pkg::SRC_CMP) begin
         ok = (mode == iwd_pkg::EXT_LOW_CODE) ||
              (mode == iwd_pkg::EXT_ANY_CHANGE_CODE) ||
              (mode == iwd_pkg::EXT_FALL_CODE) ||
              (mode == iwd_pkg::EXT_RISE_CODE);
      end else if (src == iwd_pkg::SRC_CMP) begin
         if (!mode[iwd_pkg::CMP_WINDOW_BIT]) begin
            ok = (mode[1:0] != 2'h1);
         end
      end else begin
         ok = (mode != 8'h00);
      end
      return ok;
   endfunction

   function automatic logic [3:0] pick(input logic [15:0] p,
                                       input logic        native);
      logic [3:0] k;
      k = 4'h0;
      for (int r = iwd_pkg::NUM_SRC - 1; r >= 0; r--) begin
         if (native) begin
            if (p[r]) begin
               k = 4'(r);
            end
         end else if (p[iwd_pkg::VM_ORDER[r]]) begin
            k = iwd_pkg::VM_ORDER[r];
         end
      end
      return k;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Trigger detection

   // Driven level wins while the pin is an output
   assign ext_lvl = (ext_drv_oe_n_i & st_r.ext_s2) |
                    (~ext_drv_oe_n_i & ext_drv_i);

   // Channel 0 upper limit, channel 1 lower limit
   assign win_cond[iwd_pkg::WIN_ABOVE_CODE]   =
      st_r.cmp_s2[0] & st_r.cmp_s2[1];
   assign win_cond[iwd_pkg::WIN_INSIDE_CODE]  =
      ~st_r.cmp_s2[0] & st_r.cmp_s2[1];
   assign win_cond[iwd_pkg::WIN_BELOW_CODE]   =
      ~st_r.cmp_s2[0] & ~st_r.cmp_s2[1];
   assign win_cond[iwd_pkg::WIN_OUTSIDE_CODE] =
      win_cond[iwd_pkg::WIN_ABOVE_CODE] | win_cond[iwd_pkg::WIN_BELOW_CODE];

   generate
      for (genvar i = 0; i < iwd_pkg::EXT_N; i++) begin : g_ext
         assign ev_ext[i] = ext_event(st_r.mode[i], ext_lvl[i],
                                      st_r.ext_prev[i]);
      end
      for (genvar j = 0; j < iwd_pkg::PC_N; j++) begin : g_pc
         assign ev_pc[j] =
            |((st_r.pc_s2[j] ^ st_r.pc_prev[j]) &
              st_r.mode[int'(iwd_pkg::SRC_PC0) + j]);
      end
   endgenerate

   // Source order: ext 0..7, comparator, pin-change ports
   assign ev = {ev_pc, ev_cmp, ev_ext};

   always_comb begin
      logic [7:0] m;
      logic       c;
      logic       p;
      m = st_r.mode[iwd_pkg::SRC_CMP];
      c = st_r.cmp_s2[0];
      p = st_r.cmp_prev[0];
      if (m[iwd_pkg::CMP_WINDOW_BIT]) begin
         // Entering the condition only, one event per change
         ev_cmp = win_cond[m[1:0]] & ~st_r.win_prev[m[1:0]];
      end else begin
         case (m[1:0])
            iwd_pkg::CMP_ANY_EDGE_CODE: ev_cmp = c ^ p;
            iwd_pkg::CMP_FALL_CODE:     ev_cmp = p & ~c;
            iwd_pkg::CMP_RISE_CODE:     ev_cmp = ~p & c;
            default:                    ev_cmp = 1'b0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic [15:0] clr;
      logic [15:0] set;
      logic [3:0]  k;
      logic        wb_go;
      iwd_pkg::iwd_await_t rq;
      clr   = 16'h0000;
      set   = 16'h0000;
      k     = 4'h0;
      rq    = await_event_request_i;
      wb_go = wb_cyc_i & wb_stb_i & ~st_r.ack;
      st_nxt = st_r;

      // Two-flop synchronisers, then registered copies
      st_nxt.ext_s1   = ext_pad_i;
      st_nxt.ext_s2   = st_r.ext_s1;
      st_nxt.ext_prev = ext_lvl;
      st_nxt.pc_s1    = pc_port_i;
      st_nxt.pc_s2    = st_r.pc_s1;
      st_nxt.pc_prev  = st_r.pc_s2;
      st_nxt.cmp_s1   = cmp_out_i;
      st_nxt.cmp_s2   = st_r.cmp_s1;
      st_nxt.cmp_prev = st_r.cmp_s2;
      st_nxt.win_prev = win_cond;

      // Only sources with a waiter latch an event
      st_nxt.pend = st_r.pend | (ev & st_r.waiting);

      // Lock state deliberately not consulted here
      st_nxt.wake.valid = 1'b0;
      if (irq_global_en_i && (|st_r.pend)) begin
         k = pick(st_r.pend, st_r.native);
         st_nxt.wake.valid   = 1'b1;
         st_nxt.wake.src     = k;
         st_nxt.wake.task_id = st_r.task_id[k];
         st_nxt.waiting[k]   = 1'b0;
         st_nxt.pend[k]      = 1'b0;
         set[k]              = 1'b1;
      end

      st_nxt.answer = '0;
      if (rq.valid) begin
         st_nxt.answer.done = 1'b1;
         if (st_r.waiting[rq.src] || !mode_ok(rq.src, rq.mode)) begin
            st_nxt.answer.immediate = 1'b1;
         end else begin
            st_nxt.waiting[rq.src] = 1'b1;
            st_nxt.pend[rq.src]    = 1'b0;
            st_nxt.mode[rq.src]    = rq.mode;
            st_nxt.task_id[rq.src] = rq.task_id;
         end
      end

      // Wishbone slave, one wait state
      st_nxt.ack = wb_go;
      st_nxt.dat = 32'h0000_0000;
      if (wb_go && wb_we_i) begin
         if (reg_hit(wb_adr_i, iwd_pkg::REG_CTRL) && wb_sel_i[0]) begin
            st_nxt.native = wb_dat_i[iwd_pkg::CTRL_NATIVE_BIT];
            st_nxt.muxneg = wb_dat_i[iwd_pkg::CTRL_MUXNEG_BIT];
            st_nxt.chan   = wb_dat_i[iwd_pkg::CTRL_CHAN_LSB +:
                                     iwd_pkg::CHAN_W];
         end
         if (reg_hit(wb_adr_i, iwd_pkg::REG_CLEAR)) begin
            clr = wb_dat_i[15:0] & lane_mask(wb_sel_i);
         end
         if (reg_hit(wb_adr_i, iwd_pkg::REG_ENABLE)) begin
            st_nxt.enable = (st_r.enable & ~lane_mask(wb_sel_i)) |
                            (wb_dat_i[15:0] & lane_mask(wb_sel_i));
         end
      end else if (wb_go) begin
         if (reg_hit(wb_adr_i, iwd_pkg::REG_CTRL)) begin
            st_nxt.dat[iwd_pkg::CTRL_NATIVE_BIT] = st_r.native;
            st_nxt.dat[iwd_pkg::CTRL_MUXNEG_BIT] = st_r.muxneg;
            st_nxt.dat[iwd_pkg::CTRL_CHAN_LSB +: iwd_pkg::CHAN_W] = st_r.chan;
         end
         if (reg_hit(wb_adr_i, iwd_pkg::REG_STATUS)) begin
            st_nxt.dat[15:0] = st_r.status;
         end
         if (reg_hit(wb_adr_i, iwd_pkg::REG_ENABLE)) begin
            st_nxt.dat[15:0] = st_r.enable;
         end
         if (reg_hit(wb_adr_i, iwd_pkg::REG_WAITERS)) begin
            st_nxt.dat[15:0] = st_r.waiting;
         end
      end
      // A wake in the clearing cycle keeps its bit
      st_nxt.status = (st_r.status & ~clr) | set;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign wb_ack_o       = st_r.ack;
   assign wb_dat_o       = st_r.dat;
   assign irq_o          = |(st_r.status & st_r.enable);
   assign await_answer_o = st_r.answer;
   assign wake_o         = st_r.wake;
   // Bandgap only while a comparator waiter asked for it
   assign cmp_pos_bandgap_o = st_r.waiting[iwd_pkg::SRC_CMP] &
      st_r.mode[iwd_pkg::SRC_CMP][iwd_pkg::CMP_BANDGAP_BIT];
   assign cmp_window_o      = st_r.waiting[iwd_pkg::SRC_CMP] &
      st_r.mode[iwd_pkg::SRC_CMP][iwd_pkg::CMP_WINDOW_BIT];
   assign cmp_neg_mux_o           = st_r.muxneg;
   assign analog_channel_select_o = st_r.chan;

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   a_single_waiter: assert property (@(posedge clk_i) disable iff (rst_i)
      await_event_request_i.valid &&
      st_r.waiting[await_event_request_i.src]
      |=> await_answer_o.done && await_answer_o.immediate)
      else $error("second waiter was not refused");

   a_wake_has_waiter: assert property (@(posedge clk_i) disable iff (rst_i)
      wake_o.valid |-> !st_r.waiting[wake_o.src] &&
         ((($past(st_r.waiting) >> wake_o.src) & 16'h0001) !=
          16'h0000))
      else $error("wake without waiter or waiter kept");

   a_wake_held_off: assert property (@(posedge clk_i) disable iff (rst_i)
      !irq_global_en_i ##1 wake_o.valid |-> 1'b0)
      else $error("wake delivered while interrupts disabled");

   a_lock_not_block: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_global_en_i && (|st_r.pend) && task_locked_i
      |=> wake_o.valid)
      else $error("lock blocked a wake");

   a_prompt_wake: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_global_en_i && (|st_r.pend)
      |=> wake_o.valid && $rose(st_r.status[wake_o.src]) ||
          wake_o.valid && $past(st_r.status[wake_o.src]))
      else $error("pending event not woken promptly");

   a_vm_cmp_first: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_global_en_i && !st_r.native && st_r.pend[8] &&
      st_r.pend[3] && !(|st_r.pend[2:0])
      |=> wake_o.src == iwd_pkg::SRC_CMP)
      else $error("vm order: comparator must beat ext 3");

   a_native_order: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_global_en_i && st_r.native && st_r.pend[8] &&
      st_r.pend[3] && !(|st_r.pend[2:0])
      |=> wake_o.src == 4'h3)
      else $error("native order: lowest vector must win");

   a_ext_low_lvl: assert property (@(posedge clk_i) disable iff (rst_i)
      st_r.waiting[4] && st_r.mode[4] == iwd_pkg::EXT_LOW_CODE &&
      !ext_lvl[4] |=> st_r.pend[4] || wake_o.valid)
      else $error("low level did not trigger ext 4");

   a_drive_trigger: assert property (@(posedge clk_i) disable iff (rst_i)
      st_r.waiting[1] && !ext_drv_oe_n_i[1] &&
      st_r.mode[1] == iwd_pkg::EXT_RISE_CODE &&
      !st_r.ext_prev[1] && ext_drv_i[1]
      |=> st_r.pend[1] || wake_o.valid)
      else $error("driven output edge did not trigger");

endmodule // iwd_dispatcher

`default_nettype wire

// ===== bench/iwd_far_model.sv
// Far-side model: pins, comparator outputs and task scheduler
`timescale 1ns/1ps
`default_nettype none
module iwd_far_model (
   input  wire logic               clk_i,
   input  wire iwd_pkg::iwd_wake_t wake_i,
   output var  logic [7:0]         ext_pad_o,
   output var  logic [55:0]        pc_port_o,
   output var  logic [1:0]         cmp_out_o,
   output var  logic               gie_o,
   output var  logic               lock_o
);
   logic [7:0] wq[$];
   initial begin
      ext_pad_o = 8'h00;
      pc_port_o = 56'h0;
      cmp_out_o = 2'h0;
      gie_o     = 1'b1;
      lock_o    = 1'b0;
   end
   // All lines move together so events can be simultaneous
   task automatic apply(input logic [7:0] e, input logic [55:0] p,
                        input logic [1:0] c);
      @(posedge clk_i);
      ext_pad_o <= e;
      pc_port_o <= p;
      cmp_out_o <= c;
   endtask
   task automatic sched(input logic g, input logic l);
      @(posedge clk_i);
      gie_o  <= g;
      lock_o <= l;
   endtask
   // Scheduler log, kept in arrival order
   always @(posedge clk_i) begin
      if (wake_i.valid === 1'b1) begin
         wq.push_back({wake_i.src, wake_i.task_id});
      end
   end
endmodule // iwd_far_model
`default_nettype wire

// ===== bench/tb_interrupt_wait_dispatcher.sv
// Self-checking testbench of the interrupt wait dispatcher
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module tb_interrupt_wait_dispatcher;
   logic clk_i, rst_i, cyc, stb, we, ack, irq, bg, negmux, win;
   logic [7:0] adr, drv, oe_n;
   logic [31:0] wdat, rdat, junk;
   logic [3:0] chsel;
   iwd_pkg::iwd_await_t req;
   iwd_pkg::iwd_answer_t ans;
   iwd_pkg::iwd_wake_t wk;
   int error_cnt, checks_done, cyc_cnt;
   wire logic [7:0] pad;
   wire logic [55:0] pc;
   wire logic [1:0] cmp;
   wire logic gie, lock;
   iwd_dispatcher dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
      .ext_pad_i(pad), .ext_drv_i(drv), .ext_drv_oe_n_i(oe_n),
      .pc_port_i(pc), .cmp_out_i(cmp), .cmp_pos_bandgap_o(bg),
      .cmp_neg_mux_o(negmux), .cmp_window_o(win),
      .analog_channel_select_o(chsel), .await_event_request_i(req),
      .await_answer_o(ans), .irq_global_en_i(gie),
      .task_locked_i(lock), .wake_o(wk));
   iwd_far_model far (.clk_i(clk_i), .wake_i(wk), .ext_pad_o(pad),
      .pc_port_o(pc), .cmp_out_o(cmp), .gie_o(gie), .lock_o(lock));
   always #12.5 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      `CHK(q, e)
   endtask
   task automatic ask(input logic [3:0] s, input logic [7:0] m,
                      input logic [3:0] t, input logic imm);
      @(posedge clk_i);
      req <= '{1'b1, s, m, t};
      @(posedge clk_i);
      req.valid <= 1'b0;
      @(posedge clk_i);
      `CHK({ans.done, ans.immediate}, {1'b1, imm})
   endtask
   task automatic woke(input logic [3:0] s, input logic [3:0] t);
      int n;
      logic [7:0] g;
      n = 0;
      g = 8'hxx;
      while (far.wq.size() == 0 && n < 40) begin
         @(posedge clk_i);
         n++;
      end
      if (far.wq.size() > 0) begin
         g = far.wq.pop_front();
      end
      `CHK(g, {s, t})
   endtask
   task automatic quiet(input int n);
      repeat (n) @(posedge clk_i);
      `CHK(far.wq.size(), 0)
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rd_chk(iwd_pkg::REG_ENABLE, 32'h0);
      wb(1'b1, iwd_pkg::REG_ENABLE, 32'h0000ffff, junk);
      ask(4'h0, iwd_pkg::EXT_RISE_CODE, 4'h3, 1'b0);
      ask(4'h0, iwd_pkg::EXT_FALL_CODE, 4'h5, 1'b1);
      ask(4'h1, 8'h12, 4'h5, 1'b1);
      rd_chk(iwd_pkg::REG_WAITERS, 32'h1);
      far.apply(8'h01, pc, cmp);
      woke(4'h0, 4'h3);
      rd_chk(iwd_pkg::REG_WAITERS, 32'h0);
      rd_chk(iwd_pkg::REG_STATUS, 32'h1);
      `CHK(irq, 1'b1)
      wb(1'b1, iwd_pkg::REG_ENABLE, 32'h0000fffe, junk);
      repeat (2) @(posedge clk_i);
      `CHK(irq, 1'b0)
      wb(1'b1, iwd_pkg::REG_ENABLE, 32'h0000ffff, junk);
      wb(1'b1, iwd_pkg::REG_CLEAR, 32'h1, junk);
      repeat (2) @(posedge clk_i);
      `CHK(irq, 1'b0)
      rd_chk(iwd_pkg::REG_STATUS, 32'h0);
      rd_chk(8'h20, 32'h0);
   endtask
   task automatic t_ext_codes();
      logic [7:0] codes [4];
      codes = '{iwd_pkg::EXT_LOW_CODE, iwd_pkg::EXT_ANY_CHANGE_CODE,
                iwd_pkg::EXT_FALL_CODE, iwd_pkg::EXT_RISE_CODE};
      for (int k = 0; k < 4; k++) begin
         // Falling edge needs the pin high before the waiter exists
         if (k == 2) begin
            far.apply(pad | 8'h40, pc, cmp);
            repeat (5) @(posedge clk_i);
         end
         ask(4'(k + 4), codes[k], 4'(k), 1'b0);
         if (k != 0) begin
            far.apply(pad ^ (8'h10 << k), pc, cmp);
         end
         woke(4'(k + 4), 4'(k));
      end
      far.apply(pad & 8'hfe, pc, cmp);
      quiet(8);
   endtask
   task automatic t_drive_pc();
      @(posedge clk_i);
      oe_n <= 8'hfd;
      repeat (4) @(posedge clk_i);
      ask(4'h1, iwd_pkg::EXT_RISE_CODE, 4'h7, 1'b0);
      @(posedge clk_i);
      drv <= 8'h02;
      woke(4'h1, 4'h7);
      @(posedge clk_i);
      oe_n <= 8'hff;
      drv <= 8'h00;
      ask(4'ha, 8'h00, 4'h2, 1'b1);
      ask(4'ha, 8'h21, 4'h2, 1'b0);
      far.apply(pad, pc ^ (56'h1 << 13), cmp);
      woke(4'ha, 4'h2);
   endtask
   task automatic t_prio();
      logic [3:0] s2, s3;
      for (int nat = 0; nat < 2; nat++) begin
         s2 = (nat == 1) ? 4'h3 : 4'h8;
         s3 = (nat == 1) ? 4'h8 : 4'h3;
         wb(1'b1, iwd_pkg::REG_CTRL, 32'(nat), junk);
         far.sched(1'b0, 1'b1);
         ask(4'h2, iwd_pkg::EXT_RISE_CODE, 4'h2, 1'b0);
         ask(4'h3, iwd_pkg::EXT_RISE_CODE, 4'h3, 1'b0);
         ask(4'h8, 8'h03, 4'h8, 1'b0);
         far.apply(pad | 8'h0c, pc, 2'h1);
         quiet(10);
         far.sched(1'b1, 1'b1);
         woke(4'h2, 4'h2);
         woke(s2, s2);
         woke(s3, s3);
         far.apply(pad & 8'hf3, pc, 2'h0);
         far.sched(1'b1, 1'b0);
         repeat (6) @(posedge clk_i);
      end
   endtask
   task automatic t_cmp();
      logic [7:0] md [8];
      logic [1:0] pre [8];
      logic [1:0] tgt [8];
      md = '{8'h00, 8'h02, 8'h03, 8'h43, 8'h80, 8'h81, 8'h82, 8'h83};
      pre = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h2, 2'h0, 2'h2, 2'h2};
      tgt = '{2'h1, 2'h0, 2'h1, 2'h1, 2'h3, 2'h2, 2'h0, 2'h0};
      wb(1'b1, iwd_pkg::REG_CTRL, 32'h00000052, junk);
      repeat (2) @(posedge clk_i);
      `CHK(negmux, 1'b1)
      `CHK(chsel, 4'h5)
      ask(4'h8, 8'h01, 4'h1, 1'b1);
      for (int i = 0; i < 8; i++) begin
         far.apply(pad, pc, pre[i]);
         repeat (5) @(posedge clk_i);
         ask(4'h8, md[i], 4'(i), 1'b0);
         @(posedge clk_i);
         `CHK(win, md[i][7])
         `CHK(bg, md[i][6])
         far.apply(pad, pc, tgt[i]);
         woke(4'h8, 4'(i));
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   initial begin
      clk_i = 1'b0;
      rst_i = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      wdat = 32'h0;
      req = '0;
      drv = 8'h00;
      oe_n = 8'hff;
      error_cnt = 0;
      checks_done = 0;
      cyc_cnt = 0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      t_regs();
      t_ext_codes();
      t_drive_pc();
      t_prio();
      t_cmp();
      report_and_stop();
   end
endmodule // tb_interrupt_wait_dispatcher
`default_nettype wire
